// *** hdl/cbr_top.sv ***
// smbus slave with control and status register bank of a four-output clock buffer
`timescale 1ns/1ps
`default_nettype none

// Function
// - byte 0 bits gate outputs, reset one
// - override bit picks software or latched mode
// - byte 1 bits 7:6 return latched mode
// - byte 1 bits 1:0 select output swing
// - byte 2 bits select output slew rates
// - byte 3 bit 0 selects feedback slew
// - byte 4 always reads all ones
// - byte 5 holds revision and maker codes
// - byte 6 holds device type and code
// - byte 7 sets block read length
// - block write: index, count, data, all acknowledged
// - block read returns count then data bytes
// - slave address latched once from strap
module cbr_top
  import cbr_pkg::*;
(
  // clock and reset
  input  wire logic   clk_i,
  input  wire logic   sys_rst_i,
  // smbus pins
  input  wire logic   scl_i,
  input  wire logic   sda_i,
  output logic        sda_o,
  output logic        sda_oe_n_o,
  // strap and enable pins
  input  wire logic [1:0] slave_addr_select_pin_i,
  input  wire logic [1:0] pll_mode_pin_i,
  input  wire logic [3:0] out_oe_pin_n_i,
  // controls to the analog side
  output cbr_cfg_t    cfg_o
);

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisation and edge detection
  cbr_pins_t pins_s;

  cbr_sync #(.WIDTH($bits(cbr_pins_t))) u_sync (
    .clk_i   (clk_i),
    .async_i ({scl_i, sda_i, slave_addr_select_pin_i, pll_mode_pin_i, out_oe_pin_n_i}),
    .sync_o  (pins_s)
  );

  logic scl_d_ff;
  logic sda_d_ff;
  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      scl_d_ff <= 1'b1;
      sda_d_ff <= 1'b1;
    end else begin
      scl_d_ff <= pins_s.scl;
      sda_d_ff <= pins_s.sda;
    end
  end

  assign scl_rise  = pins_s.scl & ~scl_d_ff;
  assign scl_fall  = ~pins_s.scl & scl_d_ff;
  assign start_det = pins_s.scl & scl_d_ff & sda_d_ff & ~pins_s.sda;
  assign stop_det  = pins_s.scl & scl_d_ff & ~sda_d_ff & pins_s.sda;

  ////////////////////////////////////////////////////////////////////////////
  // strap capture after reset release
  logic [1:0] strap_cnt_ff;
  logic [1:0] nxt_strap_cnt;
  logic       strap_done_ff;
  logic       nxt_strap_done;
  logic [6:0] slave_addr_ff;
  logic [6:0] nxt_slave_addr;
  logic [1:0] latched_mode_ff;
  logic [1:0] nxt_latched_mode;

  always_comb begin
    nxt_strap_cnt    = strap_cnt_ff;
    nxt_strap_done   = strap_done_ff;
    nxt_slave_addr   = slave_addr_ff;
    nxt_latched_mode = latched_mode_ff;
    if (!strap_done_ff) begin
      if (strap_cnt_ff == CBR_STRAP_WAIT) begin
        nxt_strap_done   = 1'b1;
        nxt_latched_mode = pins_s.mode_pin;
        if (pins_s.addr_sel == CBR_SEL_LO) begin
          nxt_slave_addr = CBR_ADDR_LO;
        end else if (pins_s.addr_sel == CBR_SEL_MID) begin
          nxt_slave_addr = CBR_ADDR_MID;
        end else begin
          nxt_slave_addr = CBR_ADDR_HI;
        end
      end else begin
        nxt_strap_cnt = strap_cnt_ff + 2'h1;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      strap_cnt_ff    <= '0;
      strap_done_ff   <= 1'b0;
      slave_addr_ff   <= CBR_ADDR_LO;
      latched_mode_ff <= '0;
    end else begin
      strap_cnt_ff    <= nxt_strap_cnt;
      strap_done_ff   <= nxt_strap_done;
      slave_addr_ff   <= nxt_slave_addr;
      latched_mode_ff <= nxt_latched_mode;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // register bank
  logic [63:0] regs_ff;
  logic [63:0] nxt_regs;
  logic        wr_en;
  logic [7:0]  wr_idx;
  logic [7:0]  wr_data;

  function automatic logic [7:0] rd_byte(input logic [7:0] idx, input logic [63:0] r,
                                         input logic [1:0] lm);
    logic [7:0] v;
    v = 8'h00;
    if (idx < 8'(CBR_NREG)) begin
      v = (r[idx[2:0]*8 +: 8] & CBR_WMASK[idx[2:0]*8 +: 8]) | CBR_FIXED[idx[2:0]*8 +: 8];
      if (idx == CBR_OFS_PLL_MODE_AMPLITUDE_CTRL) begin
        v[CBR_POS_LATCH_MODE +: 2] = lm;
      end
    end
    return v;
  endfunction

  always_comb begin
    nxt_regs = regs_ff;
    if (wr_en && wr_idx < 8'(CBR_NREG)) begin
      nxt_regs[wr_idx[2:0]*8 +: 8] = wr_data & CBR_WMASK[wr_idx[2:0]*8 +: 8];
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      regs_ff <= CBR_RST;
    end else begin
      regs_ff <= nxt_regs;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // control outputs
  cbr_cfg_t   cfg_ff;
  cbr_cfg_t   nxt_cfg;
  logic [7:0] b0;
  logic [7:0] b1;
  logic [7:0] b2;

  assign b0 = regs_ff[CBR_OFS_OUTPUT_ENABLE_CTRL[2:0]*8 +: 8];
  assign b1 = regs_ff[CBR_OFS_PLL_MODE_AMPLITUDE_CTRL[2:0]*8 +: 8];
  assign b2 = regs_ff[CBR_OFS_OUTPUT_SLEW_CTRL[2:0]*8 +: 8];

  always_comb begin
    for (int i = 0; i < 4; i++) begin
      nxt_cfg.out_run[i]        = b0[CBR_OUT_POS[i]] & ~pins_s.oe_pin_n[i];
      nxt_cfg.out_edge_speed[i] = b2[CBR_OUT_POS[i]];
    end
    nxt_cfg.feedback_edge_speed =
      regs_ff[CBR_OFS_FEEDBACK_SLEW_CTRL[2:0]*8 + CBR_POS_FB_SPEED];
    nxt_cfg.amplitude = b1[CBR_POS_AMPLITUDE +: 2];
    nxt_cfg.pll_mode  = b1[CBR_POS_SW_OVERRIDE] ? b1[CBR_POS_SW_MODE +: 2] : latched_mode_ff;
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      cfg_ff <= '0;
    end else begin
      cfg_ff <= nxt_cfg;
    end
  end

  assign cfg_o = cfg_ff;

  ////////////////////////////////////////////////////////////////////////////
  // smbus protocol engine
  cbr_state_t state_ff;
  cbr_state_t nxt_state;
  cbr_phase_t phase_ff;
  cbr_phase_t nxt_phase;
  logic [7:0] sh_ff;
  logic [7:0] nxt_sh;
  logic [3:0] cnt_ff;
  logic [3:0] nxt_cnt;
  logic [7:0] idx_ff;
  logic [7:0] nxt_idx;
  logic       rd_ff;
  logic       nxt_rd;
  logic       first_ff;
  logic       nxt_first;
  logic       hack_ff;
  logic       nxt_hack;
  logic       drv_ff;
  logic       nxt_drv;

  always_comb begin
    nxt_state = state_ff;
    nxt_phase = phase_ff;
    nxt_sh    = sh_ff;
    nxt_cnt   = cnt_ff;
    nxt_idx   = idx_ff;
    nxt_rd    = rd_ff;
    nxt_first = first_ff;
    nxt_hack  = hack_ff;
    wr_en     = 1'b0;
    wr_idx    = idx_ff;
    wr_data   = sh_ff;
    if (stop_det || !strap_done_ff) begin
      nxt_state = CBR_ST_IDLE;
    end else if (start_det) begin
      nxt_state = CBR_ST_RX;
      nxt_phase = CBR_PH_ADDR;
      nxt_cnt   = '0;
    end else begin
      unique case (state_ff)
        CBR_ST_IDLE: begin
        end
        CBR_ST_RX: begin
          if (scl_rise) begin
            nxt_sh  = {sh_ff[6:0], pins_s.sda};
            nxt_cnt = cnt_ff + 4'h1;
          end else if (scl_fall && cnt_ff == CBR_BYTE_BITS) begin
            nxt_state = CBR_ST_ACK;
            unique case (phase_ff)
              CBR_PH_ADDR: begin
                nxt_rd    = sh_ff[0];
                nxt_first = 1'b1;
                if (sh_ff[7:1] != slave_addr_ff) begin
                  nxt_state = CBR_ST_IDLE;
                end
              end
              CBR_PH_INDEX: nxt_idx = sh_ff;
              CBR_PH_COUNT: begin
              end
              CBR_PH_DATA: begin
                wr_en   = 1'b1;
                nxt_idx = idx_ff + 8'h01;
              end
            endcase
          end
        end
        CBR_ST_ACK: begin
          if (scl_fall) begin
            nxt_cnt = '0;
            if (rd_ff) begin
              nxt_state = CBR_ST_TX;
              nxt_first = 1'b0;
              if (first_ff) begin
                nxt_sh = regs_ff[CBR_OFS_BLOCK_READ_LENGTH[2:0]*8 +: 8] &
                         CBR_WMASK[CBR_OFS_BLOCK_READ_LENGTH[2:0]*8 +: 8];
              end else begin
                nxt_sh  = rd_byte(idx_ff, regs_ff, latched_mode_ff);
                nxt_idx = idx_ff + 8'h01;
              end
            end else begin
              nxt_state = CBR_ST_RX;
              if (phase_ff != CBR_PH_DATA) begin
                nxt_phase = cbr_phase_t'(phase_ff + 2'h1);
              end
            end
          end
        end
        CBR_ST_TX: begin
          if (scl_fall) begin
            if (cnt_ff == CBR_TX_LAST) begin
              nxt_state = CBR_ST_TXACK;
            end else begin
              nxt_sh  = {sh_ff[6:0], 1'b0};
              nxt_cnt = cnt_ff + 4'h1;
            end
          end
        end
        CBR_ST_TXACK: begin
          if (scl_rise) begin
            nxt_hack = ~pins_s.sda;
          end else if (scl_fall) begin
            nxt_cnt = '0;
            if (hack_ff) begin
              nxt_state = CBR_ST_TX;
              nxt_sh    = rd_byte(idx_ff, regs_ff, latched_mode_ff);
              nxt_idx   = idx_ff + 8'h01;
            end else begin
              nxt_state = CBR_ST_IDLE;
            end
          end
        end
        default: nxt_state = CBR_ST_IDLE;
      endcase
    end
    nxt_drv = (nxt_state == CBR_ST_ACK) || (nxt_state == CBR_ST_TX && !nxt_sh[7]);
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      state_ff <= CBR_ST_IDLE;
      phase_ff <= CBR_PH_ADDR;
      sh_ff    <= '0;
      cnt_ff   <= '0;
      idx_ff   <= '0;
      rd_ff    <= 1'b0;
      first_ff <= 1'b0;
      hack_ff  <= 1'b0;
      drv_ff   <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      phase_ff <= nxt_phase;
      sh_ff    <= nxt_sh;
      cnt_ff   <= nxt_cnt;
      idx_ff   <= nxt_idx;
      rd_ff    <= nxt_rd;
      first_ff <= nxt_first;
      hack_ff  <= nxt_hack;
      drv_ff   <= nxt_drv;
    end
  end

  // open drain: only ever pulls low
  assign sda_o      = 1'b0;
  assign sda_oe_n_o = ~drv_ff;

endmodule

`default_nettype wire

// *** pkg/cbr_pkg.sv ***
// constants, types and register map of the clock buffer register bank
package cbr_pkg;

  localparam int CBR_NREG = 8;

  // register offsets
  localparam logic [7:0] CBR_OFS_OUTPUT_ENABLE_CTRL      = 8'h00;
  localparam logic [7:0] CBR_OFS_PLL_MODE_AMPLITUDE_CTRL = 8'h01;
  localparam logic [7:0] CBR_OFS_OUTPUT_SLEW_CTRL        = 8'h02;
  localparam logic [7:0] CBR_OFS_FEEDBACK_SLEW_CTRL      = 8'h03;
  localparam logic [7:0] CBR_OFS_RESERVED_ALL_ONES       = 8'h04;
  localparam logic [7:0] CBR_OFS_REVISION_VENDOR_CODE    = 8'h05;
  localparam logic [7:0] CBR_OFS_DEVICE_TYPE_AND_CODE    = 8'h06;
  localparam logic [7:0] CBR_OFS_BLOCK_READ_LENGTH       = 8'h07;

  // identity codes, values arbitrary
  localparam logic [3:0] CBR_SILICON_REVISION_CODE = 4'h3;
  localparam logic [3:0] CBR_MAKER_CODE            = 4'h9;
  localparam logic [1:0] CBR_DEVICE_TYPE           = 2'h2;
  localparam logic [5:0] CBR_DEVICE_CODE           = 6'h2a;

  // per-byte writable mask, reset value and fixed read value, byte 0 in the low lane
  localparam logic [63:0] CBR_WMASK = {8'h1f, 8'h00, 8'h00, 8'h00, 8'h01, 8'h6a, 8'h3b, 8'h6a};
  localparam logic [63:0] CBR_RST   = {8'h08, 8'h00, 8'h00, 8'h00, 8'h01, 8'h6a, 8'h02, 8'h6a};
  localparam logic [63:0] CBR_FIXED = {8'h00, CBR_DEVICE_TYPE, CBR_DEVICE_CODE,
                                       CBR_SILICON_REVISION_CODE, CBR_MAKER_CODE,
                                       8'hff, 8'hc0, 8'h14, 8'h04, 8'h95};

  // field positions
  localparam int CBR_OUT_POS [4] = '{1, 3, 5, 6};
  localparam int CBR_POS_SW_OVERRIDE = 5;
  localparam int CBR_POS_SW_MODE     = 3;
  localparam int CBR_POS_LATCH_MODE  = 6;
  localparam int CBR_POS_AMPLITUDE   = 0;
  localparam int CBR_POS_FB_SPEED    = 0;

  // slave addresses per address-select strap (00 low, 01 mid, 10 high)
  localparam logic [1:0] CBR_SEL_LO  = 2'h0;
  localparam logic [1:0] CBR_SEL_MID = 2'h1;
  localparam logic [6:0] CBR_ADDR_LO  = 7'h6b;
  localparam logic [6:0] CBR_ADDR_MID = 7'h6c;
  localparam logic [6:0] CBR_ADDR_HI  = 7'h6d;

  // timing counts
  localparam logic [3:0] CBR_BYTE_BITS  = 4'h8;
  localparam logic [3:0] CBR_TX_LAST    = 4'h7;
  localparam logic [1:0] CBR_STRAP_WAIT = 2'h3;

  typedef enum logic [2:0] {
    CBR_ST_IDLE  = 3'b000,
    CBR_ST_RX    = 3'b001,
    CBR_ST_ACK   = 3'b010,
    CBR_ST_TX    = 3'b011,
    CBR_ST_TXACK = 3'b100
  } cbr_state_t;

  typedef enum logic [1:0] {
    CBR_PH_ADDR  = 2'b00,
    CBR_PH_INDEX = 2'b01,
    CBR_PH_COUNT = 2'b10,
    CBR_PH_DATA  = 2'b11
  } cbr_phase_t;

  // control outputs to the analog side
  typedef struct packed {
    logic [3:0] out_run;
    logic [3:0] out_edge_speed;
    logic       feedback_edge_speed;
    logic [1:0] amplitude;
    logic [1:0] pll_mode;
  } cbr_cfg_t;

  // pins after synchronisation
  typedef struct packed {
    logic       scl;
    logic       sda;
    logic [1:0] addr_sel;
    logic [1:0] mode_pin;
    logic [3:0] oe_pin_n;
  } cbr_pins_t;

endpackage

// *** hdl/cbr_sync.sv ***
// two-flop synchroniser for pin inputs
`timescale 1ns/1ps
`default_nettype none

module cbr_sync #(
  parameter int WIDTH = 1
) (
  // clock
  input  wire logic             clk_i,
  // data
  input  wire logic [WIDTH-1:0] async_i,
  output logic      [WIDTH-1:0] sync_o
);

  if (WIDTH < 1) begin : g_bad_width
    $error("cbr_sync: WIDTH must be at least 1");
  end

  logic [WIDTH-1:0] meta_ff;
  logic [WIDTH-1:0] sync_ff;

  always_ff @(posedge clk_i) begin
    meta_ff <= async_i;
    sync_ff <= meta_ff;
  end

  assign sync_o = sync_ff;

endmodule

`default_nettype wire

// *** test/cbr_top_monitor.sv ***
// concurrent checks on the ports of the clock buffer register bank
`timescale 1ns/1ps
`default_nettype none
module cbr_top_monitor
  import cbr_pkg::*;
(
  // clock and reset
  input wire logic       clk_i,
  input wire logic       sys_rst_i,
  // smbus pins
  input wire logic       scl_i,
  input wire logic       sda_i,
  input wire logic       sda_o,
  input wire logic       sda_oe_n_o,
  // strap and enable pins
  input wire logic [1:0] slave_addr_select_pin_i,
  input wire logic [1:0] pll_mode_pin_i,
  input wire logic [3:0] out_oe_pin_n_i,
  // controls
  input wire cbr_cfg_t   cfg_o
);
  logic [2:0] age_ff;
  logic [2:0] nxt_age;
  logic       settled;
  ////////////////////////////////////////////////////////////////
  // cycles since reset release, saturating
  always_comb begin
    nxt_age = (age_ff == 3'h7) ? age_ff : age_ff + 3'h1;
    if (sys_rst_i) begin
      nxt_age = 3'h0;
    end
  end
  always_ff @(posedge clk_i) begin
    age_ff <= nxt_age;
  end
  assign settled = (age_ff == 3'h7);
  ////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  a_sda_value_low: assert property (!sda_oe_n_o |-> sda_o == 1'b0)
    else $error("sda driven high");
  a_sda_scl_low: assert property ($changed(sda_oe_n_o) |-> !scl_i && !$past(scl_i, 2))
    else $error("sda moved while scl high");
  a_drive_bounded: assert property ($fell(sda_oe_n_o) |-> ##[1:200] sda_oe_n_o)
    else $error("sda held low too long");
  a_run_needs_pin: assert property (settled |-> (cfg_o.out_run & $past(out_oe_pin_n_i, 2)
    & $past(out_oe_pin_n_i, 3) & $past(out_oe_pin_n_i, 4)) == 4'h0)
    else $error("output runs with pin disabled");
  a_amp_on_bus: assert property (settled && $changed(cfg_o.amplitude) |-> !scl_i && !$past(scl_i, 4))
    else $error("swing changed outside a bus byte");
  a_slew_on_bus: assert property (settled && $changed(cfg_o.out_edge_speed) |-> !scl_i ##1 !scl_i)
    else $error("slew changed outside a bus byte");
  a_fb_on_bus: assert property (settled && $changed(cfg_o.feedback_edge_speed) |-> !$past(scl_i, 1))
    else $error("feedback slew changed outside a bus byte");
  a_mode_on_bus: assert property (settled && $changed(cfg_o.pll_mode) |-> !scl_i && !$past(scl_i, 3))
    else $error("pll mode changed outside a bus byte");
endmodule
bind cbr_top cbr_top_monitor u_mon (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .scl_i(scl_i), .sda_i(sda_i),
  .sda_o(sda_o), .sda_oe_n_o(sda_oe_n_o), .slave_addr_select_pin_i(slave_addr_select_pin_i),
  .pll_mode_pin_i(pll_mode_pin_i), .out_oe_pin_n_i(out_oe_pin_n_i), .cfg_o(cfg_o));
`default_nettype wire

// *** test/cbr_smbus_host.sv ***
// smbus host controller model issuing block writes and reads
`timescale 1ns/1ps
`default_nettype none
module cbr_smbus_host
  import cbr_pkg::*;
(
  // clock
  input  wire logic clk_i,
  // smbus wire
  input  wire logic sda_i,
  output var logic  scl_o,
  output var logic  sda_oe_n_o
);
  int nack_cnt = 0;
  initial begin
    scl_o = 1'b1;
    sda_oe_n_o = 1'b1;
  end
  ////////////////////////////////////////////////////////////////
  task automatic q();
    repeat (4) @(negedge clk_i);
  endtask
  task automatic put_bit(input logic b);
    sda_oe_n_o = b;
    q();
    scl_o = 1'b1;
    q();
    q();
    scl_o = 1'b0;
    q();
  endtask
  task automatic get_bit(output logic b);
    sda_oe_n_o = 1'b1;
    q();
    scl_o = 1'b1;
    q();
    b = sda_i;
    q();
    scl_o = 1'b0;
    q();
  endtask
  task automatic start();
    sda_oe_n_o = 1'b1;
    q();
    scl_o = 1'b1;
    q();
    sda_oe_n_o = 1'b0;
    q();
    scl_o = 1'b0;
    q();
  endtask
  task automatic stop();
    sda_oe_n_o = 1'b0;
    q();
    scl_o = 1'b1;
    q();
    sda_oe_n_o = 1'b1;
    q();
  endtask
  task automatic put_byte(input logic [7:0] d);
    logic a;
    for (int i = 7; i >= 0; i--) put_bit(d[i]);
    get_bit(a);
    if (a) nack_cnt++;
  endtask
  task automatic get_byte(output logic [7:0] d, input logic last);
    for (int i = 7; i >= 0; i--) get_bit(d[i]);
    put_bit(last);
  endtask
  ////////////////////////////////////////////////////////////////
  task automatic wr_block(input logic [6:0] a, input logic [7:0] idx, input logic [7:0] d[$]);
    start();
    put_byte({a, 1'b0});
    put_byte(idx);
    put_byte(8'(d.size()));
    foreach (d[i]) put_byte(d[i]);
    stop();
  endtask
  task automatic rd_block(input logic [6:0] a, input logic [7:0] idx, input int n, output logic [7:0] r[$]);
    logic [7:0] b;
    r = {};
    start();
    put_byte({a, 1'b0});
    put_byte(idx);
    start();
    put_byte({a, 1'b1});
    for (int i = 0; i <= n; i++) begin
      get_byte(b, i == n);
      r.push_back(b);
    end
    stop();
  endtask
endmodule
`default_nettype wire

// *** test/cbr_top_test.sv ***
// self-checking bench of the clock buffer register bank
`timescale 1ns/1ps
`default_nettype none
module cbr_top_test
  import cbr_pkg::*;
;
  localparam logic [7:0] RV = {CBR_SILICON_REVISION_CODE, CBR_MAKER_CODE};
  localparam logic [7:0] DT = {CBR_DEVICE_TYPE, CBR_DEVICE_CODE};
  logic       clk_i = 1'b0;
  logic       sys_rst_i = 1'b1;
  logic [3:0] pin_n = 4'h0;
  logic [1:0] sel_pin = 2'h0;
  logic [1:0] mode_pin = 2'h1;
  logic       scl;
  logic       h_oe_n;
  logic       sda_w;
  logic       d_sda;
  logic       d_oe_n;
  cbr_cfg_t   cfg;
  int         err_count = 0;
  int         num_checks = 0;
  always #5 clk_i = ~clk_i;
  assign sda_w = h_oe_n & (d_oe_n | d_sda);
  cbr_smbus_host host (.clk_i(clk_i), .sda_i(sda_w), .scl_o(scl), .sda_oe_n_o(h_oe_n));
  cbr_top DUT (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .scl_i(scl), .sda_i(sda_w), .sda_o(d_sda),
    .sda_oe_n_o(d_oe_n), .slave_addr_select_pin_i(sel_pin), .pll_mode_pin_i(mode_pin),
    .out_oe_pin_n_i(pin_n), .cfg_o(cfg));
  ////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [12:0] e, input logic [12:0] g);
    num_checks++;
    if (g !== e) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic cmp_rd(input logic [6:0] a, input logic [7:0] idx, input logic [7:0] e[$]);
    logic [7:0] r[$];
    host.rd_block(a, idx, e.size() - 1, r);
    foreach (e[i]) chk("rd", 13'(e[i]), 13'(r[i]));
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    repeat (40000) @(posedge clk_i);
    err_count++;
    close_out();
  end
  initial begin
    repeat (6) @(posedge clk_i);
    @(negedge clk_i);
    sys_rst_i = 1'b0;
    repeat (10) @(negedge clk_i);
    chk("cfg", {4'hf, 4'hf, 1'b1, 2'h2, 2'h1}, cfg);
    cmp_rd(CBR_ADDR_LO, 8'h00, '{8'h08, 8'hff, 8'h46, 8'h7e, 8'hc1, 8'hff, RV, DT, 8'h08});
    $display("test reset values done");
    host.wr_block(CBR_ADDR_LO, 8'h00, '{8'h00, 8'hff, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'he5});
    chk("cfg", {4'h0, 4'h0, 1'b0, 2'h3, 2'h3}, cfg);
    cmp_rd(CBR_ADDR_LO, 8'h00, '{8'h05, 8'h95, 8'h7f, 8'h14, 8'hc0, 8'hff, RV, DT, 8'h05});
    cmp_rd(CBR_ADDR_LO, 8'h05, '{8'h05, RV, DT, 8'h05, 8'h00});
    $display("test write all done");
    pin_n = 4'h8;
    host.wr_block(CBR_ADDR_LO, 8'h00, '{8'h48});
    for (int a = 0; a < 4; a++) begin
      host.wr_block(CBR_ADDR_LO, 8'h01, '{8'h10 | 8'(a)});
      chk("cfg", {4'h2, 4'h0, 1'b0, 2'(a), 2'h1}, cfg);
    end
    chk("nack", 13'h0, 13'(host.nack_cnt));
    $display("test pins and swing done");
    host.wr_block(CBR_ADDR_MID, 8'h00, '{8'h00});
    chk("nack", 13'h4, 13'(host.nack_cnt));
    chk("cfg", {4'h2, 4'h0, 1'b0, 2'h3, 2'h1}, cfg);
    $display("test address done");
    sys_rst_i = 1'b1;
    sel_pin   = CBR_SEL_MID;
    mode_pin  = 2'h2;
    repeat (2) @(negedge clk_i);
    chk("cfg", 13'h0, cfg);
    repeat (4) @(negedge clk_i);
    sys_rst_i = 1'b0;
    repeat (10) @(negedge clk_i);
    sel_pin = CBR_SEL_LO;
    chk("cfg", {4'h7, 4'hf, 1'b1, 2'h2, 2'h2}, cfg);
    cmp_rd(CBR_ADDR_MID, 8'h01, '{8'h08, 8'h86});
    host.wr_block(CBR_ADDR_LO, 8'h01, '{8'h38});
    chk("nack", 13'h8, 13'(host.nack_cnt));
    chk("cfg", {4'h7, 4'hf, 1'b1, 2'h2, 2'h2}, cfg);
    $display("test strap reset done");
    close_out();
  end
endmodule
`default_nettype wire
